// ===== common/mbst_defines.svh
// constants of the memory bus self-test: bases, patterns, counts, timing
`ifndef MBST_DEFINES_SVH
`define MBST_DEFINES_SVH

// ****************************************
// widths and sizes
// ****************************************
`define MBST_ADDR_W 20
`define MBST_DATA_W 32
`define MBST_SRAM_WORDS 262144
`define MBST_FLASH_WORDS 1048576
`define MBST_WALK_LAST 20'h0_003F
`define MBST_BEAT_LAST 20'h0_0003
`define MBST_EP_LAST 20'h0_0007
`define MBST_SDB_LAST 20'h0_0007
`define MBST_SDRD_LAST 20'h0_0001
`define MBST_HALF_LAST 20'h0_0001

// ****************************************
// test addresses and patterns
// ****************************************
`define MBST_WALK_BASE 20'h0_0100
`define MBST_BURST_BASE 20'h0_0200
`define MBST_HALF_BASE 20'h0_0210
`define MBST_BYTE_BASE 20'h0_0220
`define MBST_SDB_BASE 20'h0_0230
`define MBST_HALF_WORD 32'hC3A5_5A3C
`define MBST_BYTE_WORD 32'h8421_1248
`define MBST_BURST_SEED 32'h6996_F00F
`define MBST_EPROM_SEED 32'h0F1E_2D3C
`define MBST_SDB_SEED 8'h5A

// ****************************************
// timing
// ****************************************
`define MBST_CORE_HZ 250000000
`define MBST_MEM_HZ 66000000
// memory clock divider rounds up so the memory never runs above 66 MHz
`define MBST_MEM_DIV ((`MBST_CORE_HZ + `MBST_MEM_HZ - 1) / `MBST_MEM_HZ)
`define MBST_MEM_HALF (`MBST_MEM_DIV / 2)
`define MBST_SETTLE 2'h3

`endif

// ===== common/mbst_pkg.sv
// types of the memory bus self-test
package mbst_pkg;

  // memory access kinds
  typedef enum logic [1:0] {
    op_write = 2'b00,
    op_read = 2'b01,
    op_erase = 2'b10,
    op_init = 2'b11
  } mbst_op_t;

  // memory under test
  typedef enum logic [2:0] {
    tgt_sram_a = 3'b000,
    tgt_sram_b = 3'b001,
    tgt_flash = 3'b010,
    tgt_eprom = 3'b011,
    tgt_sdram = 3'b100
  } mbst_tgt_t;

  // test steps
  typedef enum logic [4:0] {
    st_idle = 5'b00000,
    st_sdinit = 5'b00001,
    st_erase_all = 5'b00010,
    st_addr_wr = 5'b00011,
    st_addr_rd = 5'b00100,
    st_walk_wr = 5'b00101,
    st_walk_rd = 5'b00110,
    st_burst_wr = 5'b00111,
    st_burst_rd = 5'b01000,
    st_half_wr = 5'b01001,
    st_half_rd = 5'b01010,
    st_word_wr = 5'b01011,
    st_byte_rd = 5'b01100,
    st_erase_part = 5'b01101,
    st_lane_wr = 5'b01110,
    st_word_rd = 5'b01111,
    st_ep_word = 5'b10000,
    st_ep_lo = 5'b10001,
    st_ep_hi = 5'b10010,
    st_sdb_wr = 5'b10011,
    st_sdb_rd = 5'b10100,
    st_done = 5'b10101,
    st_fail = 5'b10110,
    st_halt = 5'b10111
  } mbst_step_t;

endpackage : mbst_pkg

// ===== hdl/mbst_top.sv
// memory bus self-test sequencer with result lamps
// Operation
// RULE1: both SRAM banks, word, byte, burst
// RULE2: SRAM unique value per address, read back
// RULE3: SRAM walking ones and zeros check
// RULE4: four-beat burst write, four single reads
// RULE5: two half-word writes, one word read
// RULE6: one word write, four byte reads
// RULE7: bank lamps: first pair, second pair
// RULE8: EPROM eight words, low halves, high halves
// RULE9: EPROM reads compared with stored pattern
// RULE10: flash erase all, unique values, read back
// RULE11: flash part erase, four bytes, word read
// RULE12: flash first lamps, EPROM second lamps
// RULE13: SDRAM word, byte and burst transfers
// RULE14: SDRAM initialise, then walking pattern test
// RULE15: SDRAM eight byte writes, two word reads
// RULE16: SDRAM four-beat burst write then read
// RULE17: SDRAM pass first done, fail first fail
// RULE18: SDRAM byte masks keep one half off
// RULE19: lit lamps hold until next reset
// RULE20: done only after all steps; stop on miscompare
`include "mbst_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module mbst_top #(
  parameter int unsigned SRAM_WORDS = `MBST_SRAM_WORDS,
  parameter int unsigned FLASH_WORDS = `MBST_FLASH_WORDS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // test selection pins
  input wire logic [1:0] test_sel,
  // memory command port
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [1:0] cmd_op,
  output logic [2:0] cmd_target,
  output logic [19:0] cmd_addr,
  output logic [31:0] cmd_wdata,
  output logic [3:0] cmd_be,
  output logic cmd_burst,
  output logic cmd_last,
  // memory response port
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  // memory side
  output logic [7:0] sdram_dqm,
  output logic mem_clk,
  // result lamps
  output logic fail_lamp_a,
  output logic fail_lamp_b,
  output logic done_lamp_a,
  output logic done_lamp_b,
  output logic busy
);

  // ****************************************
  // patterns
  // ****************************************
  function automatic logic [31:0] addr_pat(input logic [19:0] a);
    addr_pat = {~a[11:0], a};
  endfunction : addr_pat

  function automatic logic [31:0] walk_pat(input logic [5:0] i);
    logic [31:0] one;
    one = 32'h0000_0001 << i[4:0];
    walk_pat = i[5] ? ~one : one;
  endfunction : walk_pat

  function automatic logic [7:0] sdb_byte(input logic [2:0] i);
    sdb_byte = `MBST_SDB_SEED ^ {5'h00, i};
  endfunction : sdb_byte

  function automatic logic [31:0] sdb_word(input logic w);
    sdb_word = {sdb_byte({w, 2'b11}), sdb_byte({w, 2'b10}),
                sdb_byte({w, 2'b01}), sdb_byte({w, 2'b00})};
  endfunction : sdb_word

  function automatic logic [3:0] lane(input logic [1:0] i);
    lane = 4'h1 << i;
  endfunction : lane

  // ****************************************
  // state
  // ****************************************
  mbst_pkg::mbst_step_t step_r;
  mbst_pkg::mbst_step_t step_nxt;
  mbst_pkg::mbst_step_t first_step;
  mbst_pkg::mbst_tgt_t tgt_r;
  mbst_pkg::mbst_op_t op;
  logic [19:0] idx_r;
  logic [19:0] last_idx;
  logic wait_r;
  logic [1:0] sel_m1_r;
  logic [1:0] sel_m2_r;
  logic [1:0] sel_m3_r;
  logic [1:0] settle_r;
  logic [1:0] div_r;
  logic is_rd;
  logic check;
  logic burst;
  logic [19:0] addr;
  logic [31:0] wdata;
  logic [31:0] expv;
  logic [3:0] be;
  logic [31:0] mask;
  logic active;
  logic want;
  logic fire;
  logic at_last;
  logic miss;
  logic lamp_b_tgt;
  logic has_succ;

  // ****************************************
  // per-step access decode
  // ****************************************
  always_comb
  begin
    op = mbst_pkg::op_read;
    is_rd = 1'b1;
    check = 1'b1;
    burst = 1'b0;
    addr = idx_r;
    wdata = 32'h0000_0000;
    expv = 32'h0000_0000;
    be = 4'hF;
    last_idx = 20'h0_0000;
    unique case (step_r)
      mbst_pkg::st_sdinit:
      begin
        op = mbst_pkg::op_init; // RULE14
        check = 1'b0;
      end
      mbst_pkg::st_erase_all:
      begin
        op = mbst_pkg::op_erase; // RULE10
        check = 1'b0;
        addr = 20'h0_0000;
      end
      mbst_pkg::st_addr_wr, mbst_pkg::st_addr_rd:
      begin
        op = (step_r == mbst_pkg::st_addr_wr) ? mbst_pkg::op_write : mbst_pkg::op_read;
        wdata = addr_pat(idx_r); // RULE2
        expv = addr_pat(idx_r); // RULE10
        last_idx = (tgt_r == mbst_pkg::tgt_flash) ? 20'(FLASH_WORDS - 1) : 20'(SRAM_WORDS - 1);
      end
      mbst_pkg::st_walk_wr, mbst_pkg::st_walk_rd:
      begin
        op = (step_r == mbst_pkg::st_walk_wr) ? mbst_pkg::op_write : mbst_pkg::op_read;
        addr = `MBST_WALK_BASE + idx_r;
        wdata = walk_pat(idx_r[5:0]); // RULE3
        expv = walk_pat(idx_r[5:0]); // RULE14
        last_idx = `MBST_WALK_LAST;
      end
      mbst_pkg::st_burst_wr, mbst_pkg::st_burst_rd:
      begin
        op = (step_r == mbst_pkg::st_burst_wr) ? mbst_pkg::op_write : mbst_pkg::op_read;
        // sram reads back beat by beat, sdram as one burst
        burst = (step_r == mbst_pkg::st_burst_wr) || (tgt_r == mbst_pkg::tgt_sdram); // RULE4 RULE16
        addr = `MBST_BURST_BASE + idx_r;
        wdata = `MBST_BURST_SEED ^ {30'h0000_0000, idx_r[1:0]};
        expv = wdata;
        last_idx = `MBST_BEAT_LAST;
      end
      mbst_pkg::st_half_wr:
      begin
        op = mbst_pkg::op_write;
        addr = `MBST_HALF_BASE;
        be = idx_r[0] ? 4'hC : 4'h3; // RULE5
        wdata = `MBST_HALF_WORD;
        last_idx = `MBST_HALF_LAST;
      end
      mbst_pkg::st_half_rd:
      begin
        addr = `MBST_HALF_BASE;
        expv = `MBST_HALF_WORD; // RULE5
      end
      mbst_pkg::st_word_wr:
      begin
        op = mbst_pkg::op_write;
        addr = `MBST_BYTE_BASE;
        wdata = `MBST_BYTE_WORD; // RULE6
      end
      mbst_pkg::st_byte_rd:
      begin
        addr = `MBST_BYTE_BASE;
        be = lane(idx_r[1:0]); // RULE6
        expv = `MBST_BYTE_WORD;
        last_idx = `MBST_BEAT_LAST;
      end
      mbst_pkg::st_erase_part:
      begin
        op = mbst_pkg::op_erase; // RULE11
        check = 1'b0;
        addr = `MBST_BYTE_BASE;
      end
      mbst_pkg::st_lane_wr:
      begin
        op = mbst_pkg::op_write;
        addr = `MBST_BYTE_BASE;
        be = lane(idx_r[1:0]); // RULE11
        wdata = `MBST_BYTE_WORD;
        last_idx = `MBST_BEAT_LAST;
      end
      mbst_pkg::st_word_rd:
      begin
        addr = `MBST_BYTE_BASE;
        expv = `MBST_BYTE_WORD; // RULE11
      end
      mbst_pkg::st_ep_word, mbst_pkg::st_ep_lo, mbst_pkg::st_ep_hi:
      begin
        be = (step_r == mbst_pkg::st_ep_lo) ? 4'h3 :
             (step_r == mbst_pkg::st_ep_hi) ? 4'hC : 4'hF; // RULE8
        expv = `MBST_EPROM_SEED ^ {8{1'b0, idx_r[2:0]}}; // RULE9
        last_idx = `MBST_EP_LAST;
      end
      mbst_pkg::st_sdb_wr:
      begin
        op = mbst_pkg::op_write;
        addr = `MBST_SDB_BASE + {19'h0_0000, idx_r[2]};
        be = lane(idx_r[1:0]); // RULE15
        wdata = {4{sdb_byte(idx_r[2:0])}};
        last_idx = `MBST_SDB_LAST;
      end
      mbst_pkg::st_sdb_rd:
      begin
        addr = `MBST_SDB_BASE + {19'h0_0000, idx_r[0]};
        expv = sdb_word(idx_r[0]); // RULE15
        last_idx = `MBST_SDRD_LAST;
      end
      default:
      begin
        check = 1'b0;
      end
    endcase
    if (op == mbst_pkg::op_write)
    begin
      is_rd = 1'b0;
      check = 1'b0;
    end
    mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  end

  // ****************************************
  // step order per memory
  // ****************************************
  always_comb
  begin
    unique case (tgt_r)
      mbst_pkg::tgt_flash: first_step = mbst_pkg::st_erase_all;
      mbst_pkg::tgt_eprom: first_step = mbst_pkg::st_ep_word;
      mbst_pkg::tgt_sdram: first_step = mbst_pkg::st_sdinit;
      default: first_step = mbst_pkg::st_addr_wr;
    endcase
    step_nxt = mbst_pkg::st_done; // RULE20
    unique case (step_r)
      mbst_pkg::st_sdinit: step_nxt = mbst_pkg::st_walk_wr; // RULE14
      mbst_pkg::st_erase_all: step_nxt = mbst_pkg::st_addr_wr;
      mbst_pkg::st_addr_wr: step_nxt = mbst_pkg::st_addr_rd;
      mbst_pkg::st_addr_rd:
        step_nxt = (tgt_r == mbst_pkg::tgt_flash) ? mbst_pkg::st_erase_part
                                                   : mbst_pkg::st_walk_wr; // RULE3
      mbst_pkg::st_walk_wr: step_nxt = mbst_pkg::st_walk_rd;
      mbst_pkg::st_walk_rd:
        step_nxt = (tgt_r == mbst_pkg::tgt_sdram) ? mbst_pkg::st_sdb_wr
                                                   : mbst_pkg::st_burst_wr;
      mbst_pkg::st_burst_wr: step_nxt = mbst_pkg::st_burst_rd;
      mbst_pkg::st_burst_rd:
        step_nxt = (tgt_r == mbst_pkg::tgt_sdram) ? mbst_pkg::st_done
                                                   : mbst_pkg::st_half_wr;
      mbst_pkg::st_half_wr: step_nxt = mbst_pkg::st_half_rd;
      mbst_pkg::st_half_rd: step_nxt = mbst_pkg::st_word_wr;
      mbst_pkg::st_word_wr: step_nxt = mbst_pkg::st_byte_rd;
      mbst_pkg::st_erase_part: step_nxt = mbst_pkg::st_lane_wr;
      mbst_pkg::st_lane_wr: step_nxt = mbst_pkg::st_word_rd;
      mbst_pkg::st_ep_word: step_nxt = mbst_pkg::st_ep_lo;
      mbst_pkg::st_ep_lo: step_nxt = mbst_pkg::st_ep_hi;
      mbst_pkg::st_sdb_wr: step_nxt = mbst_pkg::st_sdb_rd;
      mbst_pkg::st_sdb_rd: step_nxt = mbst_pkg::st_burst_wr; // RULE16
      default: step_nxt = mbst_pkg::st_done;
    endcase
  end

  // ****************************************
  // handshake terms
  // ****************************************
  assign active = (step_r != mbst_pkg::st_idle) && (step_r != mbst_pkg::st_done) &&
                  (step_r != mbst_pkg::st_fail) && (step_r != mbst_pkg::st_halt);
  assign want = active && !wait_r;
  assign fire = cmd_valid && cmd_ready;
  assign at_last = (idx_r == last_idx);
  assign miss = check && (((rsp_data ^ expv) & mask) != 32'h0000_0000);
  assign lamp_b_tgt = (tgt_r == mbst_pkg::tgt_sram_b) || (tgt_r == mbst_pkg::tgt_eprom);
  assign has_succ = (tgt_r == mbst_pkg::tgt_sram_a) || (tgt_r == mbst_pkg::tgt_flash);

  // ****************************************
  // test select pin synchroniser
  // ****************************************
  // pins are asynchronous; mode taken only once the last two stages agree
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_m1_r <= 2'h0;
      sel_m2_r <= 2'h0;
      sel_m3_r <= 2'h0;
      settle_r <= 2'h0;
    end
    else
    begin
      sel_m1_r <= test_sel;
      sel_m2_r <= sel_m1_r;
      sel_m3_r <= sel_m2_r;
      if (settle_r != `MBST_SETTLE)
        settle_r <= settle_r + 2'h1;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      step_r <= mbst_pkg::st_idle;
      tgt_r <= mbst_pkg::tgt_sram_a;
      idx_r <= 20'h0_0000;
      wait_r <= 1'b0;
    end
    else if (step_r == mbst_pkg::st_idle)
    begin
      if ((settle_r == `MBST_SETTLE) && (sel_m2_r == sel_m3_r))
      begin
        unique case (sel_m3_r)
          2'b00:
          begin
            tgt_r <= mbst_pkg::tgt_sram_a; // RULE1
            step_r <= mbst_pkg::st_addr_wr; // RULE2
          end
          2'b01:
          begin
            tgt_r <= mbst_pkg::tgt_flash;
            step_r <= mbst_pkg::st_erase_all; // RULE10
          end
          2'b10:
          begin
            tgt_r <= mbst_pkg::tgt_sdram; // RULE13
            step_r <= mbst_pkg::st_sdinit; // RULE14
          end
          default: step_r <= mbst_pkg::st_halt;
        endcase
      end
    end
    else if ((step_r == mbst_pkg::st_done) || (step_r == mbst_pkg::st_fail))
    begin
      // a failed memory stops there; its partner still gets tested
      if (has_succ)
      begin
        tgt_r <= (tgt_r == mbst_pkg::tgt_sram_a) ? mbst_pkg::tgt_sram_b
                                                 : mbst_pkg::tgt_eprom;
        step_r <= (tgt_r == mbst_pkg::tgt_sram_a) ? mbst_pkg::st_addr_wr
                                                  : mbst_pkg::st_ep_word;
      end
      else
        step_r <= mbst_pkg::st_halt;
    end
    else if (active && !is_rd)
    begin
      if (fire)
      begin
        idx_r <= at_last ? 20'h0_0000 : idx_r + 20'h0_0001;
        if (at_last)
          step_r <= step_nxt;
      end
    end
    else if (active)
    begin
      if (fire)
        wait_r <= 1'b1;
      if (wait_r && rsp_valid)
      begin
        if (miss)
        begin
          step_r <= mbst_pkg::st_fail; // RULE20
          wait_r <= 1'b0;
          idx_r <= 20'h0_0000;
        end
        else if (at_last)
        begin
          step_r <= step_nxt;
          wait_r <= 1'b0;
          idx_r <= 20'h0_0000;
        end
        else
        begin
          idx_r <= idx_r + 20'h0_0001;
          wait_r <= burst; // RULE16
        end
      end
    end
    else
      step_r <= (step_r == mbst_pkg::st_halt) ? mbst_pkg::st_halt : first_step;
  end

  // ****************************************
  // command registers
  // ****************************************
  // one idle cycle between commands keeps fields and index in step
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_valid <= 1'b0;
      cmd_op <= 2'h0;
      cmd_target <= 3'h0;
      cmd_addr <= 20'h0_0000;
      cmd_wdata <= 32'h0000_0000;
      cmd_be <= 4'h0;
      cmd_burst <= 1'b0;
      cmd_last <= 1'b0;
      sdram_dqm <= 8'hFF;
    end
    else
    begin
      cmd_valid <= want && !fire;
      cmd_op <= op;
      cmd_target <= tgt_r;
      cmd_addr <= addr;
      cmd_wdata <= wdata;
      cmd_be <= be;
      cmd_burst <= burst;
      cmd_last <= burst ? (is_rd || at_last) : 1'b1;
      // upper sdram half always masked: both halves share one data bus
      sdram_dqm <= (tgt_r == mbst_pkg::tgt_sdram) ? {4'hF, ~be} : 8'hFF; // RULE18
    end
  end

  // ****************************************
  // result lamps
  // ****************************************
  // sticky so an operator can read them long after the run
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fail_lamp_a <= 1'b0;
      fail_lamp_b <= 1'b0;
      done_lamp_a <= 1'b0;
      done_lamp_b <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      if (step_r == mbst_pkg::st_fail)
      begin
        fail_lamp_a <= fail_lamp_a | !lamp_b_tgt; // RULE7 RULE12 RULE17 RULE19
        fail_lamp_b <= fail_lamp_b | lamp_b_tgt; // RULE7 RULE12 RULE19
      end
      if (step_r == mbst_pkg::st_done)
      begin
        done_lamp_a <= done_lamp_a | !lamp_b_tgt; // RULE7 RULE12 RULE17 RULE19
        done_lamp_b <= done_lamp_b | lamp_b_tgt; // RULE7 RULE12 RULE19
      end
      busy <= active;
    end
  end

  // ****************************************
  // memory clock
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 2'h0;
      mem_clk <= 1'b0;
    end
    else if (div_r == 2'(`MBST_MEM_HALF - 1))
    begin
      div_r <= 2'h0;
      mem_clk <= ~mem_clk; // RULE1 RULE13
    end
    else
      div_r <= div_r + 2'h1;
  end

endmodule : mbst_top

`default_nettype wire

// ===== sim/mbst_top_sva.sv
// concurrent checks on the memory bus self-test ports
`timescale 1ns/100ps
`default_nettype none
module mbst_top_sva #(
  parameter int unsigned SRAM_WORDS = 16,
  parameter int unsigned FLASH_WORDS = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command and response
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_target,
  input wire logic [19:0] cmd_addr,
  input wire logic [3:0] cmd_be,
  input wire logic cmd_burst,
  input wire logic cmd_last,
  input wire logic rsp_valid,
  // memory side and lamps
  input wire logic [7:0] sdram_dqm,
  input wire logic mem_clk,
  input wire logic fail_lamp_a,
  input wire logic fail_lamp_b,
  input wire logic done_lamp_a,
  input wire logic done_lamp_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****
  // command port, memory side and lamps
  // ****
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid
    && $stable({cmd_op, cmd_target, cmd_addr, cmd_be})) else $error("command moved early");
  cmd_gap_a: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
    else $error("no idle cycle after a taken command");
  dqm_half_a: assert property (cmd_valid |-> sdram_dqm == ((cmd_target ==
    mbst_pkg::tgt_sdram) ? {4'hF, ~cmd_be} : 8'hFF)) else $error("sdram masks wrong");
  burst_last_a: assert property (cmd_valid && cmd_burst && cmd_op ==
    mbst_pkg::op_write |-> cmd_last == (cmd_addr[1:0] == 2'b11)) else $error("bad last beat");
  flash_byte_a: assert property (cmd_valid && cmd_op == mbst_pkg::op_write &&
    cmd_target == mbst_pkg::tgt_flash && cmd_be != 4'hF |-> $onehot(cmd_be))
    else $error("flash lane write not one byte");
  mem_rate_a: assert property ($changed(mem_clk) |=>
    $stable(mem_clk) ##1 $changed(mem_clk)) else $error("memory clock not core over four");
  lamp_hold_a: assert property (1 |=> fail_lamp_a >= $past(fail_lamp_a)
    && fail_lamp_b >= $past(fail_lamp_b) && done_lamp_a >= $past(done_lamp_a)
    && done_lamp_b >= $past(done_lamp_b)) else $error("lamp went dark");
  lamp_excl_a: assert property (!(fail_lamp_a && done_lamp_a)
    && !(fail_lamp_b && done_lamp_b)) else $error("done and fail both lit");
  done_cause_a: assert property ($rose(done_lamp_a) || $rose(done_lamp_b)
    |-> $past(rsp_valid, 2)) else $error("done lamp without a deciding read");
  fail_cause_a: assert property ($rose(fail_lamp_a) || $rose(fail_lamp_b)
    |-> $past(rsp_valid, 2)) else $error("fail lamp without a read");
  // main scenarios reached
  cover property ($rose(done_lamp_a));
  cover property ($rose(fail_lamp_b));
  cover property (cmd_valid && cmd_ready && cmd_burst && cmd_op == mbst_pkg::op_read);
endmodule : mbst_top_sva
bind mbst_top mbst_top_sva #(.SRAM_WORDS(SRAM_WORDS), .FLASH_WORDS(FLASH_WORDS)) i_sva (
  .core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_target, .cmd_addr, .cmd_be,
  .cmd_burst, .cmd_last, .rsp_valid, .sdram_dqm, .mem_clk, .fail_lamp_a, .fail_lamp_b,
  .done_lamp_a, .done_lamp_b);
`default_nettype wire

// ===== sim/mbst_mem_model.sv
// behavioural memories behind the self-test command port
`timescale 1ns/100ps
`default_nettype none
module mbst_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_target,
  input wire logic [19:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic [3:0] cmd_be,
  input wire logic cmd_burst,
  // response port
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  // bench controls
  input wire logic slow,
  input wire logic fault_en,
  input wire logic [2:0] fault_tgt,
  input wire logic [19:0] fault_addr
);
  // ****
  // storage
  // ****
  logic [31:0] mem [logic [22:0]];
  logic [31:0] fl [logic [19:0]];
  logic [31:0] rq [$];
  int unsigned gap;

  // stored word; f adds the read-path fault
  function automatic logic [31:0] rd(input logic [2:0] t, input logic [19:0] a, input logic f);
    logic [31:0] d;
    if (t == mbst_pkg::tgt_eprom)
      d = 32'h0F1E_2D3C ^ {8{1'b0, a[2:0]}};
    else if (t == mbst_pkg::tgt_flash)
      d = fl.exists(a) ? fl[a] : 32'hFFFF_FFFF;
    else
      d = mem.exists({t, a}) ? mem[{t, a}] : ~{12'h000, a};
    if (f && fault_en && t == fault_tgt && a == fault_addr)
      d = d ^ 32'h0001_0001;
    return d;
  endfunction : rd

  // act on a taken command
  always @(posedge core_clk)
    if (!rst && cmd_valid && cmd_ready)
    begin
      logic [31:0] w;
      w = rd(cmd_target, cmd_addr, 1'b0);
      for (int b = 0; b < 4; b++)
        if (cmd_be[b])
          w[8*b +: 8] = cmd_wdata[8*b +: 8];
      case (cmd_op)
        mbst_pkg::op_write:
          if (cmd_target == mbst_pkg::tgt_flash)
            fl[cmd_addr] = w;
          else
            mem[{cmd_target, cmd_addr}] = w;
        mbst_pkg::op_read:
          for (int i = 0; i < (cmd_burst ? 4 : 1); i++)
            rq.push_back(rd(cmd_target, cmd_addr + 20'(i), 1'b1));
        mbst_pkg::op_erase:
        begin
          if (cmd_addr == 20'h0_0000)
            fl.delete();
          else
            fl.delete(cmd_addr);
          rq.push_back(32'h0000_0000);
        end
        default:
          rq.push_back(32'h0000_0000);
      endcase
    end

  // ready and answers move off the sampling edge; slow mode stalls at random
  always @(negedge core_clk or posedge rst)
    if (rst)
    begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 32'h0000_0000;
      rq.delete();
      gap = 0;
    end
    else
    begin
      cmd_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
      if (!rsp_valid && gap == 0 && rq.size() > 0)
      begin
        rsp_valid <= 1'b1;
        rsp_data <= rq.pop_front();
        gap = slow ? $urandom_range(3, 0) : 0;
      end
      else
      begin
        rsp_valid <= 1'b0;
        rsp_data <= ~rsp_data; // released bus flips each idle cycle; the stale word returns every second one
        if (gap > 0)
          gap = gap - 1;
      end
    end
endmodule : mbst_mem_model
`default_nettype wire

// ===== sim/tb_memory_bus_self_test.sv
// self-checking bench of the memory bus self-test
`timescale 1ns/100ps
`default_nettype none
module tb_memory_bus_self_test;
  // ****
  // pins and counters
  // ****
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] test_sel = 2'b11;
  logic slow = 1'b0;
  logic fault_en = 1'b0;
  logic [2:0] fault_tgt = 3'b000;
  logic [19:0] fault_addr = 20'h0_0000;
  logic cmd_valid, cmd_ready, cmd_burst, cmd_last, rsp_valid, mem_clk, busy;
  logic fail_lamp_a, fail_lamp_b, done_lamp_a, done_lamp_b;
  logic [1:0] cmd_op;
  logic [2:0] cmd_target;
  logic [19:0] cmd_addr;
  logic [31:0] cmd_wdata, rsp_data;
  logic [3:0] cmd_be;
  logic [7:0] sdram_dqm;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2 core_clk = ~core_clk;

  // short memories keep the address pass brief
  mbst_top #(.SRAM_WORDS(16), .FLASH_WORDS(16)) i_dut (.core_clk, .rst, .test_sel,
    .cmd_valid, .cmd_ready, .cmd_op, .cmd_target, .cmd_addr, .cmd_wdata, .cmd_be,
    .cmd_burst, .cmd_last, .rsp_valid, .rsp_data, .sdram_dqm, .mem_clk, .fail_lamp_a,
    .fail_lamp_b, .done_lamp_a, .done_lamp_b, .busy);
  mbst_mem_model i_mem (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_target,
    .cmd_addr, .cmd_wdata, .cmd_be, .cmd_burst, .rsp_valid, .rsp_data, .slow, .fault_en,
    .fault_tgt, .fault_addr);

  task automatic final_report();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // lamps {fail_a, fail_b, done_a, done_b}; a pair: sram a, flash, sdram
  function automatic logic [3:0] exp_lamps(input logic [1:0] sel, input logic [2:0] ft,
    input logic fe);
    logic [2:0] ta;
    logic fa;
    logic fb;
    ta = (sel == 2'b00) ? mbst_pkg::tgt_sram_a : (sel == 2'b01) ? mbst_pkg::tgt_flash
      : mbst_pkg::tgt_sdram;
    fa = fe && ft == ta;
    fb = fe && ft == ((sel == 2'b00) ? mbst_pkg::tgt_sram_b : mbst_pkg::tgt_eprom);
    if (sel == 2'b11)
      return 4'h0;
    if (sel == 2'b10)
      return {fa, 1'b0, !fa, 1'b0};
    return {fa, fb, !fa, !fb};
  endfunction : exp_lamps

  // one reset-to-lamps run; the wait on the lamps is bounded
  task automatic run_case(input logic [1:0] sel, input logic [2:0] ft, input logic fe,
    input logic [19:0] fa, input logic sl);
    logic [3:0] exp;
    int n;
    exp = exp_lamps(sel, ft, fe);
    @(negedge core_clk);
    rst = 1'b1;
    test_sel = sel;
    fault_tgt = ft;
    fault_en = fe;
    fault_addr = fa;
    slow = sl;
    repeat (3) @(negedge core_clk);
    check({cmd_valid, busy, 2'b00, fail_lamp_a, fail_lamp_b, done_lamp_a, done_lamp_b}, 8'h00);
    check(sdram_dqm, 8'hFF);
    rst = 1'b0;
    n = 0;
    while (n < 200 || (n < 30000
      && {fail_lamp_a, fail_lamp_b, done_lamp_a, done_lamp_b} !== exp))
    begin
      @(negedge core_clk);
      n++;
    end
    repeat (20) @(negedge core_clk);
    check({4'h0, fail_lamp_a, fail_lamp_b, done_lamp_a, done_lamp_b}, {4'h0, exp});
    check({7'h00, busy}, 8'h00);
    $display("case sel %b fault %b ended, mismatches %0d", sel, fe, fails);
  endtask : run_case

  // bound on the whole run
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(99));
    run_case(2'b00, 3'b000, 1'b0, 20'h0_0000, 1'b1);
    run_case(2'b01, 3'b000, 1'b0, 20'h0_0000, 1'b1);
    run_case(2'b10, 3'b000, 1'b0, 20'h0_0000, 1'b1);
    run_case(2'b11, 3'b000, 1'b1, 20'h0_0000, 1'b0);
    run_case(2'b00, mbst_pkg::tgt_sram_a, 1'b1, 20'($urandom_range(15, 0)), 1'b0);
    run_case(2'b00, mbst_pkg::tgt_sram_a, 1'b1, 20'h0_0210, 1'b0);
    run_case(2'b00, mbst_pkg::tgt_sram_b, 1'b1, 20'h0_0203, 1'b1);
    run_case(2'b00, mbst_pkg::tgt_sram_b, 1'b1, 20'h0_0220, 1'b0);
    run_case(2'b01, mbst_pkg::tgt_flash, 1'b1, 20'h0_0220, 1'b0);
    run_case(2'b01, mbst_pkg::tgt_eprom, 1'b1, 20'($urandom_range(7, 0)), 1'b1);
    run_case(2'b10, mbst_pkg::tgt_sdram, 1'b1, 20'h0_0231, 1'b0);
    run_case(2'b10, mbst_pkg::tgt_sdram, 1'b1, 20'h0_0202, 1'b1);
    run_case(2'b10, mbst_pkg::tgt_sdram, 1'b1, 20'h0_0100 + 20'($urandom_range(63, 0)),
      1'b0);
    final_report();
  end
endmodule : tb_memory_bus_self_test
`default_nettype wire
